// File: verilog/link_cfg_pkg.sv
// constants, field layouts and reset images of the tuning / product-data
// register group; shared by the register bank and the eeprom sequencer
package link_cfg_pkg;
  localparam int BYTE_W = 8;
  localparam int BE_W   = 4;
  localparam int EE_AW  = 9;
  localparam int IDX_W  = 12;
  // configuration offsets
  localparam logic [7:0] OFF_TUNE0 = 8'hCC;
  localparam logic [7:0] OFF_TUNE1 = 8'hD0;
  localparam logic [7:0] OFF_TUNE2 = 8'hD4;
  localparam logic [7:0] OFF_VPD   = 8'hD8;
  localparam logic [7:0] OFF_VDATA = 8'hDC;
  localparam logic [7:0] OFF_IDX   = 8'hE0;
  localparam logic [7:0] OFF_WIN   = 8'hE4;
  // reset images and writable masks
  localparam logic [31:0] TUNE0_RST = 32'h0400_1060;
  localparam logic [31:0] TUNE1_RST = 32'h0400_0800;
  localparam logic [31:0] TUNE2_RST = 32'h0099_8254;
  localparam logic [31:0] ALL_MASK  = 32'hFFFF_FFFF;
  localparam logic [31:0] TUNE2_MSK = 32'h00FF_FFFF;
  localparam logic [31:0] VPD_MSK   = 32'h80FC_0000;
  localparam logic [31:0] IDX_MSK   = 32'h0000_0FFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // capability chain and eeprom displacement
  localparam logic [7:0]  CAP_ID     = 8'h03;
  localparam logic [7:0]  NEXT_PTR   = 8'hF0;
  localparam logic [7:0]  MSI_CAP_ID = 8'h05;
  localparam logic [EE_AW-1:0] EE_BASE = 9'h040;
  localparam logic [1:0]  LAST_BYTE  = 2'h3;
  typedef struct packed {
    logic [15:0] l1_entry_timer;
    logic        compliance_parity;
    logic [1:0]  nfts_sel;
    logic [4:0]  ts1_count;
    logic [2:0]  lane_negotiate_tries;
    logic        debug_sel;
    logic        goto_config;
    logic        crosslink_en;
    logic        loopback_en;
    logic        hot_reset_en;
  } tune0_type;
  typedef struct packed {
    logic [15:0] l1_lifetime;
    logic [15:0] l0s_lifetime;
  } tune1_type;
  typedef struct packed {
    logic [7:0]  rsvd;
    logic        pd_wait_en;
    logic [6:0]  l1_exit_lat;
    logic        polarity_invert;
    logic [6:0]  l0s_exit_lat;
    logic [7:0]  clock_recovery_time;
  } tune2_type;
  typedef struct packed {
    logic        op_flag;
    logic [6:0]  rsvd_hi;
    logic [5:0]  addr;
    logic [1:0]  rsvd_lo;
    logic [7:0]  next_ptr;
    logic [7:0]  cap_id;
  } vpd_ctl_type;
  typedef struct packed {
    logic [19:0] rsvd;
    logic [3:0]  ext_num;
    logic [7:0]  reg_num;
  } idx_type;
endpackage

// File: verilog/vpd_if.sv
// request / completion carrier between register bank and eeprom sequencer
// assumes both ends share sys_clk
`timescale 1ns/100ps
`default_nettype none
interface vpd_if;
  logic        start;
  logic        write;
  logic [5:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        done;
  logic        busy;
  modport ctl (output start, write, addr, wdata,
               input  rdata, done, busy);
  modport seq (input  start, write, addr, wdata,
               output rdata, done, busy);
endinterface
`default_nettype wire

// File: verilog/vpd_eeprom_seq.sv
// eeprom sequencer: one product-data word as four byte cycles
// assumes an eeprom byte port with level request held until ack
`timescale 1ns/100ps
`default_nettype none
module vpd_eeprom_seq
  import link_cfg_pkg::*;
(
  // clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // register bank side
  vpd_if.seq                    vp,
  // eeprom byte port
  output var  logic             ee_req,
  output var  logic             ee_we,
  output var  logic [EE_AW-1:0] ee_addr,
  output var  logic [7:0]       ee_wdata,
  input  wire logic             ee_ack,
  input  wire logic [7:0]       ee_rdata
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_REQ  = 4'b0010,
    S_WAIT = 4'b0100,
    S_DONE = 4'b1000
  } seq_state_type;

  seq_state_type    state_q;
  logic [1:0]       byte_q;
  logic [EE_AW-1:0] base_q;
  logic             we_q;
  logic [7:0]       word_q [BE_W];

  genvar gi;
  generate
    for (gi = 0; gi < BE_W; gi++) begin : g_lane
      assign vp.rdata[gi*BYTE_W +: BYTE_W] = word_q[gi];
    end
  endgenerate
  assign vp.busy  = (state_q != S_IDLE);
  assign vp.done  = (state_q == S_DONE);
  assign ee_we    = we_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q  <= S_IDLE;
      byte_q   <= 2'h0;
      base_q   <= EE_BASE;
      we_q     <= 1'b0;
      ee_req   <= 1'b0;
      ee_addr  <= EE_BASE;
      ee_wdata <= 8'h00;
      for (int i = 0; i < BE_W; i++) word_q[i] <= 8'h00;
    end else if (ce) begin
      case (state_q)
        S_IDLE: begin
          if (vp.start) begin
            base_q   <= EE_BASE + {1'b0, vp.addr, 2'b00};
            ee_addr  <= EE_BASE + {1'b0, vp.addr, 2'b00};
            we_q     <= vp.write;
            byte_q   <= 2'h0;
            ee_req   <= 1'b1;
            ee_wdata <= vp.wdata[BYTE_W-1:0];
            for (int i = 0; i < BE_W; i++)
              word_q[i] <= vp.wdata[i*BYTE_W +: BYTE_W];
            state_q  <= S_WAIT;
          end
        end
        S_REQ: begin
          ee_req   <= 1'b1;
          ee_addr  <= base_q + {7'h00, byte_q};
          ee_wdata <= word_q[byte_q];
          state_q  <= S_WAIT;
        end
        S_WAIT: begin
          if (ee_ack) begin
            ee_req <= 1'b0;
            if (!we_q) word_q[byte_q] <= ee_rdata;
            byte_q  <= byte_q + 2'h1;
            state_q <= (byte_q == LAST_BYTE) ? S_DONE : S_REQ;
          end
        end
        S_DONE:  state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  property p_ee_base;
    @(posedge sys_clk) disable iff (rst)
      (ce && vp.start && state_q == S_IDLE) |=>
        ee_req && ee_addr == EE_BASE + {1'b0, $past(vp.addr), 2'b00};
  endproperty
  a_ee_base: assert property (p_ee_base)
    else $error("eeprom address not displaced from product-data address");

  property p_four_bytes;
    @(posedge sys_clk) disable iff (rst)
      (state_q == S_WAIT && ee_ack && ce && byte_q == LAST_BYTE) |=>
        vp.done ##1 !vp.busy;
  endproperty
  a_four_bytes: assert property (p_four_bytes)
    else $error("word did not complete after fourth byte");
endmodule
`default_nettype wire

// File: verilog/link_tuning_vpd_cfg_access.sv
// register bank: link tuning, product-data capability, indirect window
// assumes one configuration request outstanding at a time and an
// internal register port that acks each forwarded access once
//
// Overview of operation
// - writing flag zero reads the eeprom word; flag rises when done
// - writing flag one writes the eeprom word; flag falls when done
// - eeprom location is the product-data address plus 40h
// - data register low byte is the addressed byte; byte enables work
// - window access goes to internal register at 12-bit index
// - capability header reads identifier 03h and next pointer F0h
// - clock recovery time counts fast training sets; resets 54h
// - power-down wait bit resets to one, forcing fixed wait
// - writable 16-bit L1 entry timer default, resets 0400h
// - writable 3-bit lane negotiation attempt count, resets 3h
// - software-direct bit steers training into Configuration
// - hot reset, loopback and crosslink enables reset to zero
// - writable compliance pattern parity bit, resets zero
// - writable 7-bit L0s and L1 exit latencies, reset 2h and 19h
// - writable 2-bit fast training count select, resets 0h
// - next pointer F0h is not decoded here; reads of F0h return zero
`timescale 1ns/100ps
`default_nettype none
module link_tuning_vpd_cfg_access
  import link_cfg_pkg::*;
(
  // clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // configuration access
  input  wire logic             cfg_req,
  input  wire logic             cfg_we,
  input  wire logic [7:0]       cfg_addr,
  input  wire logic [BE_W-1:0]  cfg_be,
  input  wire logic [31:0]      cfg_wdata,
  output var  logic             cfg_ack,
  output var  logic [31:0]      cfg_rdata,
  // internal configuration register port
  output var  logic             ext_req,
  output var  logic             ext_we,
  output var  logic [IDX_W-1:0] ext_index,
  output var  logic [BE_W-1:0]  ext_be,
  output var  logic [31:0]      ext_wdata,
  input  wire logic             ext_ack,
  input  wire logic [31:0]      ext_rdata,
  // eeprom byte port
  output var  logic             ee_req,
  output var  logic             ee_we,
  output var  logic [EE_AW-1:0] ee_addr,
  output var  logic [7:0]       ee_wdata,
  input  wire logic             ee_ack,
  input  wire logic [7:0]       ee_rdata,
  // training state machine controls
  output var  logic             hot_reset_en,
  output var  logic             loopback_en,
  output var  logic             crosslink_en,
  output var  logic             goto_config,
  output var  logic             debug_sel,
  output var  logic [2:0]       lane_negotiate_tries,
  output var  logic [4:0]       ts1_count,
  output var  logic [1:0]       nfts_sel,
  output var  logic             compliance_parity,
  output var  logic [15:0]      l1_entry_timer,
  // low-power timers and physical tuning
  output var  logic [15:0]      l0s_lifetime,
  output var  logic [15:0]      l1_lifetime,
  output var  logic [7:0]       clock_recovery_time,
  output var  logic [6:0]       l0s_exit_lat,
  output var  logic             receive_lane_pair_invert,
  output var  logic [6:0]       l1_exit_lat,
  output var  logic             pd_wait_en
);
  tune0_type   tune0_q;
  tune1_type   tune1_q;
  tune2_type   tune2_q;
  logic [5:0]  vpd_addr_q;
  logic        vpd_flag_q;
  logic [31:0] vpd_data_q;
  idx_type     idx_q;
  logic        win_busy_q;
  vpd_ctl_type ctl_img;
  vpd_ctl_type wr_img;
  logic [31:0] rd_word;
  logic        take;
  logic        wr;
  logic        vpd_start;

  vpd_if vp ();

  vpd_eeprom_seq u_seq (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .ce       (ce),
    .vp       (vp),
    .ee_req   (ee_req),
    .ee_we    (ee_we),
    .ee_addr  (ee_addr),
    .ee_wdata (ee_wdata),
    .ee_ack   (ee_ack),
    .ee_rdata (ee_rdata)
  );

  // byte-enabled merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [BE_W-1:0] be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = ZERO_WORD;
    for (int i = 0; i < BE_W; i++)
      m[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
    m = m & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // register write strobe for one offset
  function automatic logic hit(input logic [7:0] off);
    return wr && (cfg_addr == off);
  endfunction

  assign take = cfg_req && !win_busy_q;
  assign wr   = take && cfg_we;

  // flag write ignored while a cycle runs
  assign vpd_start = hit(OFF_VPD) && cfg_be[3] && !vp.busy;
  assign vp.start  = vpd_start;
  assign wr_img    = vpd_ctl_type'(cfg_wdata);
  assign vp.write  = wr_img.op_flag;
  assign vp.addr   = cfg_be[2] ? wr_img.addr : vpd_addr_q;
  assign vp.wdata  = vpd_data_q;

  assign hot_reset_en         = tune0_q.hot_reset_en;
  assign loopback_en          = tune0_q.loopback_en;
  assign crosslink_en         = tune0_q.crosslink_en;
  assign goto_config          = tune0_q.goto_config;
  assign debug_sel            = tune0_q.debug_sel;
  assign lane_negotiate_tries = tune0_q.lane_negotiate_tries;
  assign ts1_count            = tune0_q.ts1_count;
  assign nfts_sel             = tune0_q.nfts_sel;
  assign compliance_parity    = tune0_q.compliance_parity;
  assign l1_entry_timer       = tune0_q.l1_entry_timer;
  assign l0s_lifetime         = tune1_q.l0s_lifetime;
  assign l1_lifetime          = tune1_q.l1_lifetime;
  assign clock_recovery_time  = tune2_q.clock_recovery_time;
  assign l0s_exit_lat         = tune2_q.l0s_exit_lat;
  assign receive_lane_pair_invert = tune2_q.polarity_invert;
  assign l1_exit_lat          = tune2_q.l1_exit_lat;
  assign pd_wait_en           = tune2_q.pd_wait_en;

  // tuning registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tune0_q <= tune0_type'(TUNE0_RST);
      tune1_q <= tune1_type'(TUNE1_RST);
      tune2_q <= tune2_type'(TUNE2_RST);
    end else if (ce) begin
      if (hit(OFF_TUNE0))
        tune0_q <= tune0_type'(merge(tune0_q, cfg_wdata, cfg_be,
                                     ALL_MASK));
      if (hit(OFF_TUNE1))
        tune1_q <= tune1_type'(merge(tune1_q, cfg_wdata, cfg_be,
                                     ALL_MASK));
      if (hit(OFF_TUNE2))
        tune2_q <= tune2_type'(merge(tune2_q, cfg_wdata, cfg_be,
                                     TUNE2_MSK));
    end
  end

  // product-data address and operation flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vpd_addr_q <= 6'h00;
      vpd_flag_q <= 1'b0;
    end else if (ce) begin
      if (hit(OFF_VPD) && cfg_be[2] && !vp.busy)
        vpd_addr_q <= vp.addr;
      if (vp.done)
        vpd_flag_q <= !vpd_flag_q;
      else if (vpd_start)
        vpd_flag_q <= vp.write;
    end
  end

  // product-data word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vpd_data_q <= ZERO_WORD;
    end else if (ce) begin
      if (vp.done && !vpd_flag_q)
        vpd_data_q <= vp.rdata;
      else if (hit(OFF_VDATA))
        vpd_data_q <= merge(vpd_data_q, cfg_wdata, cfg_be, ALL_MASK);
    end
  end

  // indirect index
  always_ff @(posedge sys_clk) begin
    if (rst)
      idx_q <= idx_type'(ZERO_WORD);
    else if (ce && hit(OFF_IDX))
      idx_q <= idx_type'(merge(idx_q, cfg_wdata, cfg_be, IDX_MSK));
  end

  // next pointer leads to message interrupts
  always_comb begin
    ctl_img          = vpd_ctl_type'(ZERO_WORD);
    ctl_img.cap_id   = CAP_ID;
    ctl_img.next_ptr = NEXT_PTR;
    ctl_img.addr     = vpd_addr_q;
    ctl_img.op_flag  = vpd_flag_q;
  end

  always_comb begin
    case (cfg_addr)
      OFF_TUNE0: rd_word = tune0_q;
      OFF_TUNE1: rd_word = tune1_q;
      OFF_TUNE2: rd_word = tune2_q;
      OFF_VPD:   rd_word = ctl_img;
      OFF_VDATA: rd_word = vpd_data_q;
      OFF_IDX:   rd_word = idx_q;
      default:   rd_word = ZERO_WORD;
    endcase
  end

  // indirect window forwarding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_req    <= 1'b0;
      ext_we     <= 1'b0;
      ext_index  <= 12'h000;
      ext_be     <= 4'h0;
      ext_wdata  <= ZERO_WORD;
      win_busy_q <= 1'b0;
    end else if (ce) begin
      ext_req <= 1'b0;
      if (take && cfg_addr == OFF_WIN) begin
        ext_req    <= 1'b1;
        ext_we     <= cfg_we;
        ext_index  <= {idx_q.ext_num, idx_q.reg_num};
        ext_be     <= cfg_be;
        ext_wdata  <= cfg_wdata;
        win_busy_q <= 1'b1;
      end else if (win_busy_q && ext_ack) begin
        win_busy_q <= 1'b0;
      end
    end
  end

  // completion to the configuration requester
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= ZERO_WORD;
    end else if (ce) begin
      cfg_ack <= 1'b0;
      if (take && cfg_addr != OFF_WIN) begin
        cfg_ack   <= 1'b1;
        cfg_rdata <= cfg_we ? ZERO_WORD : rd_word;
      end else if (win_busy_q && ext_ack) begin
        cfg_ack   <= 1'b1;
        cfg_rdata <= ext_we ? ZERO_WORD : ext_rdata;
      end
    end
  end

  property p_read_flag;
    @(posedge sys_clk) disable iff (rst)
      (ce && vpd_start && !cfg_wdata[31]) |=>
        !vpd_flag_q throughout (vp.busy [*2]);
  endproperty
  a_read_flag: assert property (p_read_flag)
    else $error("flag not held low during eeprom read");

  property p_read_done;
    @(posedge sys_clk) disable iff (rst)
      (ce && vp.done && !vpd_flag_q) |=> vpd_flag_q && !vp.busy;
  endproperty
  a_read_done: assert property (p_read_done)
    else $error("flag not set after eeprom read");

  property p_write_done;
    @(posedge sys_clk) disable iff (rst)
      (ce && vp.done && vpd_flag_q) |=> !vpd_flag_q;
  endproperty
  a_write_done: assert property (p_write_done)
    else $error("flag not cleared after eeprom write");

  property p_window;
    @(posedge sys_clk) disable iff (rst)
      (ce && take && cfg_addr == OFF_WIN) |=>
        ext_req && ext_index == {$past(idx_q.ext_num),
                                 $past(idx_q.reg_num)};
  endproperty
  a_window: assert property (p_window)
    else $error("window access not forwarded to indexed register");

  property p_cap_hdr;
    @(posedge sys_clk) disable iff (rst)
      (ce && take && !cfg_we && cfg_addr == OFF_VPD) |=>
        cfg_ack && cfg_rdata[15:0] == {NEXT_PTR, CAP_ID};
  endproperty
  a_cap_hdr: assert property (p_cap_hdr)
    else $error("capability header mismatch");

  property p_rst_tune2;
    @(posedge sys_clk) $past(rst) |->
      tune2_q.pd_wait_en && tune2_q.clock_recovery_time == 8'h54;
  endproperty
  a_rst_tune2: assert property (p_rst_tune2)
    else $error("tuning 2 reset value wrong");

  property p_rst_tune0;
    @(posedge sys_clk) $past(rst) |->
      tune0_q.lane_negotiate_tries == 3'h3 && !goto_config &&
      !hot_reset_en && !loopback_en && !crosslink_en;
  endproperty
  a_rst_tune0: assert property (p_rst_tune0)
    else $error("tuning 0 reset value wrong");

  property p_steer;
    @(posedge sys_clk) disable iff (rst)
      (ce && hit(OFF_TUNE0) && cfg_be[0]) |=>
        goto_config == $past(cfg_wdata[3]);
  endproperty
  a_steer: assert property (p_steer)
    else $error("software-direct bit did not follow write");

  property p_rst_life;
    @(posedge sys_clk) $past(rst) |->
      l0s_lifetime == 16'h0800 && l1_lifetime == 16'h0400 &&
      l1_entry_timer == 16'h0400;
  endproperty
  a_rst_life: assert property (p_rst_life)
    else $error("lifetime reset value wrong");

  property p_rst_lat;
    @(posedge sys_clk) $past(rst) |->
      l0s_exit_lat == 7'h02 && l1_exit_lat == 7'h19 &&
      nfts_sel == 2'h0 && !compliance_parity;
  endproperty
  a_rst_lat: assert property (p_rst_lat)
    else $error("latency reset value wrong");
endmodule
`default_nettype wire

// File: testbench/vpd_eeprom_model.sv
// eeprom byte-port model holding product data
// assumes level request held until ack; answer delay varies with address
`timescale 1ns/100ps
`default_nettype none
module vpd_eeprom_model (
  // clock
  input  wire logic       sys_clk,
  // byte request
  input  wire logic       ee_req,
  input  wire logic       ee_we,
  input  wire logic [8:0] ee_addr,
  input  wire logic [7:0] ee_wdata,
  // byte answer
  output var  logic       ee_ack,
  output var  logic [7:0] ee_rdata
);
  logic [7:0] mem [0:511];
  logic [8:0] a;
  initial begin
    ee_ack   = 1'b0;
    ee_rdata = 8'h00;
    for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h5A;
    forever begin
      @(posedge sys_clk);
      #1;
      if (ee_req === 1'b1) begin
        a = ee_addr;
        // prompt or slow answer, 0 to 3 cycles
        repeat (a[1:0]) @(posedge sys_clk);
        #1;
        ee_ack   = 1'b1;
        ee_rdata = mem[a];
        if (ee_we === 1'b1) mem[a] = ee_wdata;
        @(posedge sys_clk);
        #1;
        ee_ack   = 1'b0;
        ee_rdata = ~ee_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/link_tuning_vpd_cfg_access_tb.sv
// register sequences on the configuration port with expected values
// assumes the eeprom model and a window responder in this bench
`timescale 1ns/100ps
`default_nettype none
module link_tuning_vpd_cfg_access_tb;
  import link_cfg_pkg::*;
  logic sys_clk, rst, ce, cfg_req, cfg_we, cfg_ack, ext_req, ext_we, ext_ack;
  logic ee_req, ee_we, ee_ack, hot_reset_en, loopback_en, crosslink_en;
  logic goto_config, debug_sel, compliance_parity, pd_wait_en;
  logic receive_lane_pair_invert;
  logic [7:0]  cfg_addr, ee_wdata, ee_rdata, clock_recovery_time;
  logic [3:0]  cfg_be, ext_be;
  logic [31:0] cfg_wdata, cfg_rdata, ext_wdata, ext_rdata, rd_q;
  logic [11:0] ext_index;
  logic [8:0]  ee_addr;
  logic [2:0]  lane_negotiate_tries;
  logic [4:0]  ts1_count;
  logic [1:0]  nfts_sel;
  logic [15:0] l1_entry_timer, l0s_lifetime, l1_lifetime;
  logic [6:0]  l0s_exit_lat, l1_exit_lat;
  int          fail_count, check_count;

  link_tuning_vpd_cfg_access u_dut (.sys_clk, .rst, .ce, .cfg_req, .cfg_we,
    .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .ext_req, .ext_we,
    .ext_index, .ext_be, .ext_wdata, .ext_ack, .ext_rdata, .ee_req, .ee_we,
    .ee_addr, .ee_wdata, .ee_ack, .ee_rdata, .hot_reset_en, .loopback_en,
    .crosslink_en, .goto_config, .debug_sel, .lane_negotiate_tries,
    .ts1_count, .nfts_sel, .compliance_parity, .l1_entry_timer, .l0s_lifetime,
    .l1_lifetime, .clock_recovery_time, .l0s_exit_lat,
    .receive_lane_pair_invert, .l1_exit_lat, .pd_wait_en);
  vpd_eeprom_model u_ee (.sys_clk, .ee_req, .ee_we, .ee_addr, .ee_wdata,
    .ee_ack, .ee_rdata);

  function automatic logic [7:0] ev(input int a);
    return 8'(a) ^ 8'h5A;
  endfunction
  function automatic logic [31:0] ew(input int k);
    return {ev('h43 + 4*k), ev('h42 + 4*k), ev('h41 + 4*k), ev('h40 + 4*k)};
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one configuration access, pulse request, bounded wait for ack
  task automatic acc(input logic we, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    int i;
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge sys_clk) #1;
    cfg_req = 1'b0;
    for (i = 0; i < 40 && cfg_ack !== 1'b1; i++) @(posedge sys_clk) #1;
    if (cfg_ack !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    rd_q = cfg_rdata;
    @(posedge sys_clk) #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 4'hF, 32'h0);
    chk($sformatf("offset %h", a), e, rd_q);
  endtask
  task automatic poll(input logic v);
    for (int i = 0; i < 200; i++) begin
      acc(1'b0, OFF_VPD, 4'hF, 32'h0);
      if (rd_q[31] === v) return;
    end
    fail_count++;
    stop_test();
  endtask
  // start an eeprom read, try a refused restart, then check the word
  task automatic vpd_rd(input logic [5:0] k, input logic [31:0] e);
    acc(1'b1, OFF_VPD, 4'b1100, {8'h00, k, 18'h0});
    rd(OFF_VPD, {8'h00, k, 18'h0F003});
    acc(1'b1, OFF_VPD, 4'b1100, {8'h80, 6'h2A, 18'h0});
    poll(1'b1);
    rd(OFF_VPD, {8'h80, k, 18'h0F003});
    rd(OFF_VDATA, e);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // window responder: ack two cycles after each forwarded access
  initial begin
    ext_ack = 1'b0;
    ext_rdata = 32'h0;
    forever begin
      @(posedge sys_clk) #1;
      if (ext_req === 1'b1) begin
        repeat (2) @(posedge sys_clk);
        #1 ext_ack = 1'b1;
        ext_rdata = {20'hC0DE0, ext_index};
        @(posedge sys_clk) #1 ext_ack = 1'b0;
        ext_rdata = ~ext_rdata;
      end
    end
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    rd(OFF_TUNE0, 32'h0400_1060);
    rd(OFF_TUNE1, 32'h0400_0800);
    rd(OFF_TUNE2, 32'h0099_8254);
    rd(OFF_VPD, 32'h0000_F003);
    rd(OFF_VDATA, 32'h0);
    rd(OFF_IDX, 32'h0);
    chk("tries", 32'h3, 32'(lane_negotiate_tries));
    chk("recovery", 32'h54, 32'(clock_recovery_time));
    chk("pdwait", 32'h1, 32'(pd_wait_en));
    chk("lat", 32'h1982, {l1_exit_lat, receive_lane_pair_invert,
        l0s_exit_lat});
    chk("ctl", 32'h0, {hot_reset_en, loopback_en, crosslink_en, goto_config,
        compliance_parity, nfts_sel});
    chk("life", 32'h0400_0800, {l1_lifetime, l0s_lifetime});
    acc(1'b1, OFF_TUNE0, 4'hF, 32'hFFFF_FFFF);
    rd(OFF_TUNE0, 32'hFFFF_FFFF);
    chk("ctl1", 32'hFFFF_FFFF, {hot_reset_en, loopback_en, crosslink_en,
        goto_config, debug_sel, lane_negotiate_tries, ts1_count, nfts_sel,
        compliance_parity, l1_entry_timer});
    acc(1'b1, OFF_TUNE0, 4'b1100, 32'h1234_0000);
    chk("l1tmr", 32'h1234, 32'(l1_entry_timer));
    acc(1'b1, OFF_TUNE2, 4'hF, 32'hFFFF_FFFF);
    rd(OFF_TUNE2, 32'h00FF_FFFF);
    chk("l1lat", 32'h7F, 32'(l1_exit_lat));
    acc(1'b1, OFF_TUNE2, 4'hF, 32'h0);
    chk("pdwait0", 32'h0, 32'(pd_wait_en));
    acc(1'b1, OFF_TUNE1, 4'b0010, 32'hAABB_CCDD);
    rd(OFF_TUNE1, 32'h0400_CC00);
    ce = 1'b0;
    cfg_req = 1'b1;
    cfg_we = 1'b1;
    cfg_addr = OFF_TUNE1;
    cfg_be = 4'hF;
    cfg_wdata = 32'h0;
    @(posedge sys_clk) #1;
    cfg_req = 1'b0;
    ce = 1'b1;
    chk("frozen", 32'h0, 32'(cfg_ack));
    rd(OFF_TUNE1, 32'h0400_CC00);
    acc(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    acc(1'b1, OFF_VPD, 4'b0011, 32'h0000_FFFF);
    rd(OFF_VPD, 32'h0000_F003);
    acc(1'b1, OFF_IDX, 4'hF, 32'hFFFF_FABC);
    rd(OFF_IDX, 32'h0000_0ABC);
    rd(OFF_WIN, 32'hC0DE_0ABC);
    chk("rdidx", 32'h0ABC, {20'h0, ext_index});
    acc(1'b1, OFF_WIN, 4'b0101, 32'h1357_9BDF);
    chk("wr", {20'h0, 4'h5, 8'h1}, {20'h0, ext_be, 7'h0, ext_we});
    chk("wdata", 32'h1357_9BDF, ext_wdata);
    vpd_rd(6'd0, ew(0));
    vpd_rd(6'd5, ew(5));
    acc(1'b1, OFF_VDATA, 4'hF, 32'h1122_3344);
    acc(1'b1, OFF_VPD, 4'b1100, {8'h80, 6'h3F, 18'h0});
    rd(OFF_VPD, {8'h80, 6'h3F, 18'h0F003});
    poll(1'b0);
    chk("eeword", 32'h1122_3344, {u_ee.mem['h13F], u_ee.mem['h13E],
        u_ee.mem['h13D], u_ee.mem['h13C]});
    acc(1'b1, OFF_VDATA, 4'hF, 32'h0);
    vpd_rd(6'h3F, 32'h1122_3344);
    rst = 1'b1;
    @(posedge sys_clk) #1;
    rst = 1'b0;
    rd(OFF_TUNE0, 32'h0400_1060);
    rd(OFF_VDATA, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
